/* File: inc/mabie_pkg.sv */
// Constants and types shared by the instruction execution block.
package mabie_pkg;
    localparam int INSTR_W = 12;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 5;
    localparam int PC_W = 9;
    localparam int BIDX_W = 3;
    // Opcode fields, aligned to the top of the instruction word.
    localparam logic [5:0] OPC_ADD_F = 6'h07;
    localparam logic [5:0] OPC_AND_F = 6'h05;
    localparam logic [3:0] OPC_AND_K = 4'he;
    localparam logic [3:0] OPC_BIT_RESET = 4'h4;
    localparam logic [3:0] OPC_BIT_ASSERT = 4'h5;
    localparam logic [3:0] OPC_SKIP_LOW = 4'h6;
    localparam logic [3:0] OPC_SKIP_HIGH = 4'h7;
    localparam logic [11:0] OPC_DIR_LOAD = 12'h006;
    // Field positions within the instruction word.
    localparam int TOP4_MSB = 11;
    localparam int TOP4_LSB = 8;
    localparam int TOP6_LSB = 6;
    localparam int DEST_BIT = 5;
    localparam int BIDX_MSB = 7;
    localparam int BIDX_LSB = 5;
    localparam int FADDR_MSB = 4;
    localparam int LIT_MSB = 7;
    // File addresses with side effects.
    localparam logic [4:0] TIMER_ADDR = 5'h01;
    localparam logic [4:0] PC_ADDR = 5'h02;
    localparam logic [4:0] PORT_ADDR = 5'h06;
    // Reset values, then byte constants and the nibble top-bit index.
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] PORT_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'hff;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] ONE_BYTE = 8'h01;
    localparam int NIB_MSB = 3;
    typedef enum logic {MABIE_IDLE, MABIE_EXEC} mabie_state_e;
endpackage : mabie_pkg

/* File: hdl/mabie_file_mem.sv */
// Data file register array with a registered read port.
`timescale 1ns/10ps
module mabie_file_mem
    import mabie_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [mabie_pkg::ADDR_W-1:0] rd_addr,
    output logic [mabie_pkg::DATA_W-1:0] rd_data,
    input wire logic wr_en,
    input wire logic [mabie_pkg::ADDR_W-1:0] wr_addr,
    input wire logic [mabie_pkg::DATA_W-1:0] wr_data
);
    logic [DATA_W-1:0] mem_reg [0:(1<<ADDR_W)-1];

    // No reset: file contents are undefined at power-up, as in the core.
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        rd_data <= mem_reg[rd_addr];
    end
endmodule : mabie_file_mem

/* File: hdl/mabie_exec.sv */
// Execution unit for add, AND, bit and skip instructions of an 8-bit core.
`timescale 1ns/10ps
// Operation
// - Any PC write except absolute jump forces PC bit eight to zero.
// - Port read-modify-write uses pin levels, not the output latch.
// - Direction-load with operand 6 copies accumulator to port direction.
// - A direction bit of one turns that pin's output driver off.
// - Writing the timer count clears the prescaler when assigned to timer.
// - Add sums accumulator and file, routes by target bit, sets carry flags.
// - File AND routes result by target bit and updates only zero flag.
// - Immediate AND with eight-bit literal into accumulator, updates zero.
// - Bit reset clears bit 0-7 of file 0-31, flags unchanged.
// - Bit assert sets the selected file bit, flags unchanged.
// - Skip-if-low discards next instruction when bit is zero.
// - Skip-if-high discards next instruction when bit is one.
// - Bit ops decode by top four bits with index and address fields.
module mabie_exec
    import mabie_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [mabie_pkg::INSTR_W-1:0] instr_word,
    output logic instr_ready,
    output logic exec_done,
    output logic skip_next,
    input wire logic prescaler_to_timer,
    output logic prescaler_clear,
    output logic pc_load_valid,
    output logic [mabie_pkg::PC_W-1:0] pc_load_value,
    output logic [mabie_pkg::DATA_W-1:0] accumulator,
    output logic carry_flag,
    output logic nibble_overflow_bit,
    output logic zero_flag,
    input wire logic [mabie_pkg::DATA_W-1:0] pin_in,
    output logic [mabie_pkg::DATA_W-1:0] pin_out,
    output logic [mabie_pkg::DATA_W-1:0] pin_oe,
    output logic [mabie_pkg::DATA_W-1:0] pin_direction_latch
);
    import mabie_pkg::*;

    // Every check below samples on the core clock and sleeps during reset.
    default clocking core_cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    function automatic logic [DATA_W-1:0] bit_mask(
        input logic [BIDX_W-1:0] idx);
        bit_mask = ONE_BYTE << idx;
    endfunction : bit_mask

    mabie_state_e state_reg;
    logic [INSTR_W-1:0] instr_reg;
    logic [DATA_W-1:0] mem_rdata;
    logic [DATA_W-1:0] file_val;
    logic [ADDR_W-1:0] faddr;
    logic [BIDX_W-1:0] bidx;
    logic [3:0] top4;
    logic [5:0] top6;
    logic dest_file;
    logic accept;
    logic in_exec;
    logic [DATA_W-1:0] result;
    logic [DATA_W:0] sum9;
    logic [NIB_MSB+1:0] sum_nib;
    logic is_add, is_and_f, is_and_k, is_reset, is_assert;
    logic is_skip_low, is_skip_high, is_dir_load;
    logic wr_acc, wr_file, upd_z, upd_cdc, do_skip;

    assign accept = instr_valid && instr_ready;
    assign in_exec = (state_reg == MABIE_EXEC);
    assign faddr = instr_reg[FADDR_MSB:0];
    assign bidx = instr_reg[BIDX_MSB:BIDX_LSB];
    assign top4 = instr_reg[TOP4_MSB:TOP4_LSB];
    assign top6 = instr_reg[TOP4_MSB:TOP6_LSB];
    assign dest_file = instr_reg[DEST_BIT];
    // The port operand is the pin level so an input held low reads zero.
    assign file_val = (faddr == PORT_ADDR) ? pin_in : mem_rdata;

    assign is_add = (top6 == OPC_ADD_F);
    assign is_and_f = (top6 == OPC_AND_F);
    assign is_and_k = (top4 == OPC_AND_K);
    assign is_reset = (top4 == OPC_BIT_RESET);
    assign is_assert = (top4 == OPC_BIT_ASSERT);
    assign is_skip_low = (top4 == OPC_SKIP_LOW);
    assign is_skip_high = (top4 == OPC_SKIP_HIGH);
    assign is_dir_load = (instr_reg == OPC_DIR_LOAD);
    assign sum9 = {1'b0, accumulator} + {1'b0, file_val};
    assign sum_nib = {1'b0, accumulator[NIB_MSB:0]}
        + {1'b0, file_val[NIB_MSB:0]};

    always_comb begin
        result = ZERO_BYTE;
        wr_acc = 1'b0;
        wr_file = 1'b0;
        upd_z = 1'b0;
        upd_cdc = 1'b0;
        do_skip = 1'b0;
        if (is_add) begin
            result = sum9[DATA_W-1:0];
            wr_acc = !dest_file;
            wr_file = dest_file;
            upd_z = 1'b1;
            upd_cdc = 1'b1;
        end else if (is_and_f) begin
            result = accumulator & file_val;
            wr_acc = !dest_file;
            wr_file = dest_file;
            upd_z = 1'b1;
        end else if (is_and_k) begin
            result = accumulator & instr_reg[LIT_MSB:0];
            wr_acc = 1'b1;
            upd_z = 1'b1;
        end else if (is_reset) begin
            result = file_val & ~bit_mask(bidx);
            wr_file = 1'b1;
        end else if (is_assert) begin
            result = file_val | bit_mask(bidx);
            wr_file = 1'b1;
        end else if (is_skip_low) begin
            do_skip = !file_val[bidx];
        end else if (is_skip_high) begin
            do_skip = file_val[bidx];
        end
    end

    // Port writes land in the output latch, not the file array.
    mabie_file_mem u_file_mem (
        .ref_clk(ref_clk),
        .rd_addr(instr_word[FADDR_MSB:0]),
        .rd_data(mem_rdata),
        .wr_en(in_exec && wr_file && (faddr != PORT_ADDR)),
        .wr_addr(faddr),
        .wr_data(result)
    );

    // One cycle to read the file operand, one to execute.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= MABIE_IDLE;
            instr_ready <= 1'b0;
            instr_reg <= '0;
        end else begin
            case (state_reg)
                MABIE_IDLE: begin
                    instr_ready <= !accept;
                    if (accept) begin
                        instr_reg <= instr_word;
                        state_reg <= MABIE_EXEC;
                    end
                end
                MABIE_EXEC: begin
                    instr_ready <= 1'b1;
                    state_reg <= MABIE_IDLE;
                end
                default: begin
                    instr_ready <= 1'b0;
                    state_reg <= MABIE_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            exec_done <= 1'b0;
            skip_next <= 1'b0;
        end else begin
            exec_done <= in_exec;
            skip_next <= in_exec && do_skip;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            accumulator <= ACC_RST;
            zero_flag <= 1'b0;
            carry_flag <= 1'b0;
            nibble_overflow_bit <= 1'b0;
        end else if (in_exec) begin
            if (wr_acc) begin
                accumulator <= result;
            end
            if (upd_z) begin
                zero_flag <= (result == ZERO_BYTE);
            end
            if (upd_cdc) begin
                carry_flag <= sum9[DATA_W];
                nibble_overflow_bit <= sum_nib[NIB_MSB+1];
            end
        end
    end

    // The low byte of the PC is written as data; bit eight is always cleared.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_load_valid <= 1'b0;
            pc_load_value <= '0;
            prescaler_clear <= 1'b0;
        end else begin
            pc_load_valid <= in_exec && wr_file && (faddr == PC_ADDR);
            pc_load_value <= {1'b0, result};
            prescaler_clear <= in_exec && wr_file && (faddr == TIMER_ADDR)
                && prescaler_to_timer;
        end
    end

    // Output enables are kept as their own flops so the pins stay registered.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out <= PORT_RST;
            pin_direction_latch <= DIR_RST;
            pin_oe <= ~DIR_RST;
        end else if (in_exec) begin
            if (wr_file && (faddr == PORT_ADDR)) begin
                pin_out <= result;
            end
            if (is_dir_load) begin
                pin_direction_latch <= accumulator;
                pin_oe <= ~accumulator;
            end
        end
    end

    a_pc_bit_clear: assert property (pc_load_valid |->
        !pc_load_value[PC_W-1])
        else $error("PC bit eight not cleared");
    a_port_from_pins: assert property (
        in_exec && is_assert && faddr == PORT_ADDR
        |=> pin_out == ($past(pin_in) | bit_mask($past(bidx))))
        else $error("Port write did not use pin levels");
    a_dir_load_copy: assert property (
        in_exec && is_dir_load
        |=> pin_direction_latch == $past(accumulator))
        else $error("Direction latch not loaded");
    a_dir_disables_oe: assert property (
        pin_oe == ~pin_direction_latch)
        else $error("Driver enable does not follow direction latch");
    a_prescaler_clear: assert property (
        in_exec && wr_file && faddr == TIMER_ADDR && prescaler_to_timer
        |=> prescaler_clear)
        else $error("Prescaler not cleared");
    a_add_to_acc: assert property (
        in_exec && is_add && !dest_file
        |=> accumulator == $past(sum9[DATA_W-1:0])
        && carry_flag == $past(sum9[DATA_W]))
        else $error("Add result or carry wrong");
    a_and_flags: assert property (
        in_exec && (is_and_f || is_and_k)
        |=> $stable(carry_flag) && $stable(nibble_overflow_bit))
        else $error("AND altered carry flags");
    a_and_k_result: assert property (
        in_exec && is_and_k |=> accumulator ==
        ($past(accumulator) & $past(instr_reg[LIT_MSB:0])))
        else $error("Immediate AND result wrong");
    a_bit_ops_flags: assert property (
        in_exec && (is_reset || is_assert) |=> $stable(zero_flag)
        && $stable(carry_flag) && $stable(accumulator))
        else $error("Bit op altered flags");
    a_skip_low: assert property (
        in_exec && is_skip_low |=> skip_next == !$past(file_val[bidx]))
        else $error("Skip-if-low wrong");
    a_skip_high: assert property (
        in_exec && is_skip_high |=> skip_next == $past(file_val[bidx]))
        else $error("Skip-if-high wrong");
    a_zero_flag: assert property (
        in_exec && upd_z |=> zero_flag == ($past(result) == ZERO_BYTE))
        else $error("Zero flag wrong");
    a_nibble_carry: assert property (
        in_exec && is_add |=> nibble_overflow_bit == $past(sum_nib[NIB_MSB+1]))
        else $error("Nibble overflow wrong");
    c_skip_taken: cover property (skip_next);
    c_add_carry: cover property (in_exec && is_add && sum9[DATA_W]);
    c_dir_load: cover property (in_exec && is_dir_load);
    c_prescaler: cover property (prescaler_clear);
endmodule : mabie_exec

/* File: test/mcu_alu_bit_instr_exec_test.sv */
// Self-checking testbench for the add, AND, bit and skip execution unit.
`timescale 1ns/10ps
module mcu_alu_bit_instr_exec_test;
    import mabie_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic instr_valid = 1'b0;
    logic [INSTR_W-1:0] instr_word = 12'h000;
    logic prescaler_to_timer = 1'b0;
    logic [DATA_W-1:0] pin_in = 8'h00;
    logic instr_ready, exec_done, skip_next, prescaler_clear, pc_load_valid;
    logic [PC_W-1:0] pc_load_value;
    logic [DATA_W-1:0] accumulator, pin_out, pin_oe, pin_direction_latch;
    logic carry_flag, nibble_overflow_bit, zero_flag;
    int num_errors = 0;
    int total_checks = 0;
    // Xorshift state, started from 36320 so every run is repeatable.
    logic [31:0] seed = 32'h00008de0;
    int mem [32];
    int m_acc, m_c, m_dc, m_z, m_out, m_dir;
    int e_skip, e_pc, e_pcv, e_clr;

    mabie_exec i_mabie_exec (.ref_clk(ref_clk), .rst_n(rst_n),
        .instr_valid(instr_valid), .instr_word(instr_word),
        .instr_ready(instr_ready), .exec_done(exec_done),
        .skip_next(skip_next), .prescaler_to_timer(prescaler_to_timer),
        .prescaler_clear(prescaler_clear), .pc_load_valid(pc_load_valid),
        .pc_load_value(pc_load_value), .accumulator(accumulator),
        .carry_flag(carry_flag), .nibble_overflow_bit(nibble_overflow_bit),
        .zero_flag(zero_flag), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_direction_latch(pin_direction_latch));

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] next_rand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : next_rand

    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string name, input int exp,
                       input logic [8:0] got);
        logic [8:0] e;
        e = 9'(exp);
        total_checks++;
        if (got !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, e, got);
        end
    endtask : chk

    // Reference model; port reads take the pin levels, never the latch.
    task automatic predict(input logic [11:0] w);
        int f, b, a, r, wr;
        f = int'(w[4:0]);
        b = int'(w[7:5]);
        wr = 0;
        r = 0;
        e_skip = 0;
        e_pc = 0;
        e_clr = 0;
        a = (f == 6) ? int'(pin_in) : mem[f];
        if (w[11:6] == OPC_ADD_F) begin
            r = m_acc + a;
            m_c = (r > 255);
            m_dc = ((m_acc % 16) + (a % 16)) > 15;
            r = r % 256;
            m_z = (r == 0);
            wr = 1;
        end else if (w[11:6] == OPC_AND_F) begin
            r = m_acc & a;
            m_z = (r == 0);
            wr = 1;
        end else if (w[11:8] == OPC_AND_K) begin
            m_acc = m_acc & int'(w[7:0]);
            m_z = (m_acc == 0);
        end else if (w[11:8] == OPC_BIT_RESET) begin
            r = a & ~(1 << b);
            wr = 2;
        end else if (w[11:8] == OPC_BIT_ASSERT) begin
            r = a | (1 << b);
            wr = 2;
        end else if (w[11:8] == OPC_SKIP_LOW) begin
            e_skip = (((a >> b) & 1) == 0);
        end else if (w[11:8] == OPC_SKIP_HIGH) begin
            e_skip = (((a >> b) & 1) == 1);
        end else if (w == OPC_DIR_LOAD) begin
            m_dir = m_acc;
        end
        if (wr == 1 && !w[DEST_BIT]) begin
            m_acc = r;
        end else if (wr != 0) begin
            if (f == 6) begin
                m_out = r;
            end else begin
                mem[f] = r;
            end
            e_pc = (f == 2);
            e_pcv = r;
            e_clr = (f == 1) && prescaler_to_timer;
        end
    endtask : predict

    // Entered and left at a falling edge, so calls run back to back.
    task automatic run_op(input logic [11:0] w);
        int n;
        n = 0;
        instr_valid = 1'b1;
        instr_word = w;
        while (instr_ready !== 1'b1 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        if (n == 20) begin
            num_errors++;
            give_verdict();
        end
        predict(w);
        @(negedge ref_clk);
        instr_valid = 1'b0;
        chk("instr_ready", 0, instr_ready);
        chk("early exec_done", 0, exec_done);
        @(negedge ref_clk);
        chk("exec_done", 1, exec_done);
        chk("skip_next", e_skip, skip_next);
        chk("pc_load_valid", e_pc, pc_load_valid);
        if (e_pc != 0) chk("pc_load_value", e_pcv, pc_load_value);
        chk("prescaler_clear", e_clr, prescaler_clear);
        chk("accumulator", m_acc, accumulator);
        chk("carry", m_c, carry_flag);
        chk("nibble", m_dc, nibble_overflow_bit);
        chk("zero", m_z, zero_flag);
        chk("pin_out", m_out, pin_out);
        chk("direction", m_dir, pin_direction_latch);
        chk("pin_oe", ~m_dir & 255, pin_oe);
    endtask : run_op

    initial begin
        int i;
        int p;
        logic [31:0] r;
        logic [4:0] f;
        logic [11:0] w;
        m_acc = 0;
        m_c = 0;
        m_dc = 0;
        m_z = 0;
        m_out = 0;
        m_dir = 255;
        repeat (12) @(negedge ref_clk);
        chk("reset ready", 0, instr_ready);
        chk("reset acc", 0, accumulator);
        chk("reset dir", 255, pin_direction_latch);
        chk("reset oe", 0, pin_oe);
        chk("reset out", 0, pin_out);
        rst_n = 1'b1;
        // File bytes power up unknown; AND with a clear accumulator zeroes
        // them, touching the timer and program counter addresses as well.
        for (p = 0; p < 2; p++) begin
            prescaler_to_timer = p[0];
            for (i = 0; i < 32; i++) begin
                if (i != 6) run_op({OPC_AND_F, 1'b1, 5'(i)});
            end
        end
        for (i = 0; i < 600; i++) begin
            r = next_rand();
            pin_in = r[7:0];
            prescaler_to_timer = r[8];
            f = r[13:9];
            if (r[15:14] == 2'h0) f = PORT_ADDR;
            case (r[18:16])
                3'h0: w = {OPC_ADD_F, r[19], f};
                3'h1: w = {OPC_AND_F, r[19], f};
                3'h2: w = {OPC_AND_K, r[31:24]};
                3'h3: w = {OPC_BIT_RESET, r[22:20], f};
                3'h4: w = {OPC_BIT_ASSERT, r[22:20], f};
                3'h5: w = {OPC_SKIP_LOW, r[22:20], f};
                3'h6: w = {OPC_SKIP_HIGH, r[22:20], f};
                default: w = r[19] ? OPC_DIR_LOAD : 12'h000;
            endcase
            run_op(w);
        end
        give_verdict();
    end
endmodule : mcu_alu_bit_instr_exec_test
